// File: rtl/dma_pkg.sv
// Package: register layout, field encodings and reset values of the arbiter control block
package dma_pkg;
    // Register offset of the second arbiter control word
    localparam logic [7:0]  DMA_CTL2_OFS       = 8'h04;
    // Field positions
    localparam int          DMA_WB_LIM_LSB     = 28;
    localparam int          DMA_SB_LIM_LSB     = 26;
    localparam int          DMA_P5_LIM_LSB     = 18;
    localparam int          DMA_FC_LIM_LSB     = 16;
    localparam int          DMA_TRICKLE_BIT    = 12;
    localparam int          DMA_LP_RD_LSB      = 9;
    localparam int          DMA_HP_RD_LSB      = 4;
    localparam int          DMA_ISOCH_BIT      = 3;
    localparam int          DMA_TAG_WM_LSB     = 0;
    // Writable bits: 31,29:26,19:16,13,12,11,10:9,5:4,3,1:0; bit 2 is treated as must-be-zero
    localparam logic [31:0] DMA_CTL2_WMASK     = 32'hbc0f_3e3b;
    // Value after reset: limits 4,4,4,2, LP reads 4, HP reads 128, tag watermark 8
    localparam logic [31:0] DMA_CTL2_RESET     = 32'h2809_0600;
    // Burst counter width covers the largest limit of 16
    localparam int          DMA_CNT_W          = 5;
    localparam int          DMA_NUM_CLIENTS    = 4;
    // Client indices
    localparam int          DMA_CL_WB          = 0;
    localparam int          DMA_CL_SB          = 1;
    localparam int          DMA_CL_P5          = 2;
    localparam int          DMA_CL_FC          = 3;
    // Arbiter states
    typedef enum logic [1:0]
    {
        DMA_IDLE  = 2'b01,
        DMA_BURST = 2'b10
    } dma_state_t;
endpackage : dma_pkg

// File: rtl/dma_arb_ctl.sv
// Display memory arbiter control: register, burst limits, in-flight limits, priority gating
// What this block does
// - Write-back client burst limited 1/2/4/8, default 4
// - State-buffer client burst limited 1/2/4/8, default 4
// - Fifth client burst limited 1/2/4/16, default 4
// - Frame-compression burst limited 1/2/4/8, default 2
// - Trickle bit: high-priority request allows all trickle
// - Low-priority reads in flight at most 1..4
// - High-priority reads in flight at most 128..16
// - Isochronous enable: demote at transition watermark
// - No watermark enabled: demote when buffer full
// - Only primary instance isochronous bit takes effect
// - Tag watermark encodes 8/16/32, 11b reserved
// - High priority starts only at tag level >= watermark
`timescale 1ns/1ns
`default_nettype none
module dma_arb_ctl
    import dma_pkg::*;
#(
    parameter bit PRIMARY = 1'b1
)
(
    // Clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    // Register port
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [7:0]                 reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    output logic      [31:0]                reg_rdata_o,
    // Isochronous enable from the primary instance
    input  wire logic                       isoch_primary_i,
    output logic                            isoch_enable_o,
    // Low-priority write clients
    input  wire logic [DMA_NUM_CLIENTS-1:0] client_req_i,
    output logic      [DMA_NUM_CLIENTS-1:0] client_gnt_o,
    // Read transaction accounting
    input  wire logic                       lp_rd_req_i,
    output logic                            lp_rd_ok_o,
    input  wire logic                       lp_rd_done_i,
    input  wire logic                       hp_rd_req_i,
    output logic                            hp_rd_ok_o,
    input  wire logic                       hp_rd_done_i,
    input  wire logic [5:0]                 tag_level_i,
    // Trickle feed
    input  wire logic [DMA_NUM_CLIENTS-1:0] client_hp_i,
    output logic                            trickle_allow_o,
    // Isochronous demotion
    input  wire logic                       trans_wm_en_i,
    input  wire logic                       trans_wm_hit_i,
    input  wire logic                       buf_full_i,
    output logic                            demote_o,
    // Status
    output logic      [7:0]                 lp_inflight_o,
    output logic      [7:0]                 hp_inflight_o
);

    // Control word, arbitration state and counters
    logic [31:0]          ctl_q;
    logic [31:0]          ctl_d;
    logic [31:0]          rdata_d;
    dma_state_t           state_q;
    logic [1:0]           owner_q;
    logic [DMA_CNT_W-1:0] burst_q;
    logic [7:0]           lp_cnt_q;
    logic [7:0]           lp_cnt_d;
    logic [7:0]           hp_cnt_q;
    logic [7:0]           hp_cnt_d;
    logic [1:0]           rr_q;
    // Decoded fields, limits and gates
    logic [1:0]           wb_code;
    logic [1:0]           sb_code;
    logic [1:0]           p5_code;
    logic [1:0]           fc_code;
    logic [1:0]           pick;
    logic                 pick_v;
    logic [DMA_CNT_W-1:0] limit_cur;
    logic [7:0]           lp_lim;
    logic [7:0]           hp_lim;
    logic [5:0]           tag_wm;
    logic                 lp_go;
    logic                 hp_go;
    logic                 at_limit;
    logic                 owner_left;
    logic                 end_burst;

    // Burst limit decode; large code differs only for the fifth client
    function automatic logic [DMA_CNT_W-1:0] burst_lim(input logic [1:0] code, input logic big16);
        case (code)
            2'b00:   burst_lim = 5'd1;
            2'b01:   burst_lim = 5'd2;
            2'b10:   burst_lim = 5'd4;
            default: burst_lim = big16 ? 5'd16 : 5'd8;
        endcase
    endfunction : burst_lim

    // Register write; masked bits stay zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ctl_q <= DMA_CTL2_RESET;
        else
            ctl_q <= ctl_d;
    end

    // Next control word; bits outside the mask stay zero
    always_comb
    begin
        ctl_d = ctl_q;
        if (reg_wr_i && reg_addr_i == DMA_CTL2_OFS)
            ctl_d = reg_wdata_i & DMA_CTL2_WMASK;
    end

    // Read data from a flop; unmapped offsets read zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i)
            reg_rdata_o <= rdata_d;
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        if (reg_addr_i == DMA_CTL2_OFS)
            rdata_d = ctl_q;
        else
            rdata_d = 32'h0000_0000;
    end

    // Secondary instances ignore their own bit
    assign isoch_enable_o = PRIMARY ? ctl_q[DMA_ISOCH_BIT] : isoch_primary_i;

    // Demotion at watermark, or at full buffer without one
    assign demote_o = isoch_enable_o && (trans_wm_en_i ? trans_wm_hit_i : buf_full_i);

    // Trickle permission follows any high-priority request
    assign trickle_allow_o = ctl_q[DMA_TRICKLE_BIT] && (|client_hp_i);

    // Field views of the burst limit codes
    assign wb_code = ctl_q[DMA_WB_LIM_LSB +: 2];
    assign sb_code = ctl_q[DMA_SB_LIM_LSB +: 2];
    assign p5_code = ctl_q[DMA_P5_LIM_LSB +: 2];
    assign fc_code = ctl_q[DMA_FC_LIM_LSB +: 2];

    // In-flight limits; HP code counts down from 128
    assign lp_lim = 8'd1 + {6'd0, ctl_q[DMA_LP_RD_LSB +: 2]};
    assign hp_lim = 8'd128 >> ctl_q[DMA_HP_RD_LSB +: 2];
    // Reserved code 11b treated as the 32-tag setting
    // Strictest level chosen so a bad code never loosens the gate
    always_comb
    begin
        case (ctl_q[DMA_TAG_WM_LSB +: 2])
            2'b00:   tag_wm = 6'd8;
            2'b01:   tag_wm = 6'd16;
            default: tag_wm = 6'd32;
        endcase
    end

    assign lp_go      = lp_cnt_q < lp_lim;
    assign hp_go      = (hp_cnt_q < hp_lim) && (tag_level_i >= tag_wm);
    assign lp_rd_ok_o = lp_go;
    assign hp_rd_ok_o = hp_go;
    assign lp_inflight_o = lp_cnt_q;
    assign hp_inflight_o = hp_cnt_q;

    // Next low-priority count; a stray completion at zero is ignored
    always_comb
    begin
        lp_cnt_d = lp_cnt_q;
        if (lp_rd_req_i && lp_go)
            lp_cnt_d = lp_cnt_d + 8'd1;
        if (lp_rd_done_i && lp_cnt_q != 8'd0)
            lp_cnt_d = lp_cnt_d - 8'd1;
    end

    // Low-priority outstanding count
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            lp_cnt_q <= 8'd0;
        else
            lp_cnt_q <= lp_cnt_d;
    end

    // Next high-priority count; issue and completion may share a cycle
    always_comb
    begin
        hp_cnt_d = hp_cnt_q;
        if (hp_rd_req_i && hp_go)
            hp_cnt_d = hp_cnt_d + 8'd1;
        if (hp_rd_done_i && hp_cnt_q != 8'd0)
            hp_cnt_d = hp_cnt_d - 8'd1;
    end

    // High-priority outstanding count
    // Counter width leaves room above the largest limit of 128
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hp_cnt_q <= 8'd0;
        else
            hp_cnt_q <= hp_cnt_d;
    end

    // Limit of the current owner
    always_comb
    begin
        case (owner_q)
            2'd0:    limit_cur = burst_lim(wb_code, 1'b0);
            2'd1:    limit_cur = burst_lim(sb_code, 1'b0);
            2'd2:    limit_cur = burst_lim(p5_code, 1'b1);
            default: limit_cur = burst_lim(fc_code, 1'b0);
        endcase
    end

    // Round-robin pick starting after last owner
    // Starting past the owner keeps a busy client from starving others
    always_comb
    begin
        pick   = rr_q;
        pick_v = 1'b0;
        for (int i = 0; i < DMA_NUM_CLIENTS; i++)
        begin
            if (!pick_v && client_req_i[2'(rr_q + 2'(i))])
            begin
                pick   = 2'(rr_q + 2'(i));
                pick_v = 1'b1;
            end
        end
    end

    // Burst ends at the limit or when the owner drops its request
    assign at_limit   = (burst_q + 5'd1) >= limit_cur;
    assign owner_left = !client_req_i[owner_q];
    assign end_burst  = at_limit || owner_left;

    // Grant follows the owner while its burst lasts
    // Grant drops at once when the owner withdraws
    always_comb
    begin
        client_gnt_o = '0;
        if (state_q == DMA_BURST && client_req_i[owner_q])
            client_gnt_o[owner_q] = 1'b1;
    end

    // Arbitration state; one idle cycle between bursts
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_q <= DMA_IDLE;
        else
        begin
            case (state_q)
                DMA_IDLE:
                begin
                    if (pick_v)
                        state_q <= DMA_BURST;
                end
                DMA_BURST:
                begin
                    // Re-arbitrate so others get a turn
                    if (end_burst)
                        state_q <= DMA_IDLE;
                end
                default:
                    state_q <= DMA_IDLE;
            endcase
        end
    end

    // Owner latched when a burst starts
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            owner_q <= 2'd0;
        else if (state_q == DMA_IDLE && pick_v)
            owner_q <= pick;
    end

    // Beats of the current burst; cleared outside a burst
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            burst_q <= '0;
        else if (state_q == DMA_BURST && !end_burst)
            burst_q <= burst_q + 5'd1;
        else
            burst_q <= '0;
    end

    // Round-robin pointer moves past the owner at burst end
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rr_q <= 2'd0;
        else if (state_q == DMA_BURST && end_burst)
            rr_q <= owner_q + 2'd1;
    end

endmodule : dma_arb_ctl
`default_nettype wire

// File: test/dma_arb_ctl_asserts.sv
// Checker: port properties of the arbiter control block
`timescale 1ns/1ns
`default_nettype none
module dma_arb_ctl_asserts
    import dma_pkg::*;
(
    // Subset of the ports watched, inputs only
    input  wire logic        clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, hp_rd_ok_o, trickle_allow_o, isoch_enable_o,
    input  wire logic        trans_wm_en_i, trans_wm_hit_i, buf_full_i, demote_o,
    input  wire logic [3:0]  client_gnt_o, client_hp_i,
    input  wire logic [5:0]  tag_level_i,
    input  wire logic [7:0]  reg_addr_i, lp_inflight_o, hp_inflight_o,
    input  wire logic [31:0] reg_wdata_i, reg_rdata_o
);
    logic [31:0] ctl_q;
    logic [4:0]  run_q;
    logic [3:0]  gnt_q;
    logic [6:0]  wm;
    logic [4:0]  lim;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow of the control word, so limits are known without a read
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
        if (!rst_n_i) ctl_q <= DMA_CTL2_RESET;
        else if (reg_wr_i && reg_addr_i == DMA_CTL2_OFS) ctl_q <= ctl_q & ~DMA_CTL2_WMASK | reg_wdata_i & DMA_CTL2_WMASK;
    // Length of the current grant run
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
        if (!rst_n_i) {run_q, gnt_q} <= '0;
        else {run_q, gnt_q} <= {client_gnt_o == '0 ? 5'h0 : client_gnt_o == gnt_q ? run_q + 5'h1 : 5'h1, client_gnt_o};
    // Reserved watermark code 11b acts as 32
    assign wm  = 7'h8 << (ctl_q[1] ? 2'h2 : {1'b0, ctl_q[0]});
    assign lim = client_gnt_o[0] ? 5'h1 << ctl_q[29:28] : client_gnt_o[1] ? 5'h1 << ctl_q[27:26] :
                 client_gnt_o[2] ? (ctl_q[19:18] == 2'h3 ? 5'h10 : 5'h1 << ctl_q[19:18]) : 5'h1 << ctl_q[17:16];
    sequence rd_s;
        reg_rd_i && reg_addr_i == DMA_CTL2_OFS;
    endsequence
    burst_limit_a: assert property (client_gnt_o != '0 |-> run_q <= lim) else $error("grant run too long");
    trickle_a: assert property (trickle_allow_o == (ctl_q[12] && |client_hp_i)) else $error("trickle wrong");
    lp_cap_a: assert property (lp_inflight_o <= ctl_q[10:9] + 8'h1) else $error("lp over limit");
    hp_cap_a: assert property (hp_inflight_o <= 8'h80 >> ctl_q[5:4]) else $error("hp over limit");
    isoch_wm_a: assert property (isoch_enable_o && trans_wm_en_i && trans_wm_hit_i |-> demote_o) else $error("no demote");
    isoch_full_a: assert property (isoch_enable_o && !trans_wm_en_i |-> demote_o == buf_full_i) else $error("demote");
    isoch_src_a: assert property (isoch_enable_o == ctl_q[3]) else $error("isoch enable wrong");
    hp_gate_a: assert property (hp_rd_ok_o |-> tag_level_i >= wm) else $error("hp below watermark");
    rd_map_a: assert property (rd_s |=> reg_rdata_o == $past(ctl_q)) else $error("read data wrong");
    mbz_read_a: assert property (reg_rd_i |=> (reg_rdata_o & ~DMA_CTL2_WMASK) == '0) else $error("mbz set");
endmodule : dma_arb_ctl_asserts
bind dma_arb_ctl dma_arb_ctl_asserts i_dma_arb_ctl_asserts (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .hp_rd_ok_o,
    .trickle_allow_o, .isoch_enable_o, .trans_wm_en_i, .trans_wm_hit_i, .buf_full_i, .demote_o, .client_gnt_o,
    .client_hp_i, .tag_level_i, .reg_addr_i, .lp_inflight_o, .hp_inflight_o, .reg_wdata_i, .reg_rdata_o);
`default_nettype wire

// File: test/dma_fabric_model.sv
// Memory fabric model: completes issued reads one per cycle
`timescale 1ns/1ns
`default_nettype none
module dma_fabric_model
(
    // Clock, reset, issue and completion
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic issue_i,
    input  wire logic stall_i,
    output logic      done_o
);
    logic [7:0] owed_q;
    // Stall models a slow fabric so the in-flight counts can fill
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
        if (!rst_n_i) {owed_q, done_o} <= '0;
        else {owed_q, done_o} <= {owed_q + 8'(issue_i) - 8'(!stall_i && owed_q != 8'h0), !stall_i && owed_q != 8'h0};
endmodule : dma_fabric_model
`default_nettype wire

// File: test/dma_arb_ctl_tb.sv
// Testbench: registers, burst limits, read limits and priority policy
`timescale 1ns/1ns
`default_nettype none
module dma_arb_ctl_tb;
    import dma_pkg::*;
    logic        clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, isoch_primary_i, isoch_enable_o, trickle_allow_o, demote_o;
    logic        lp_rd_req_i, lp_rd_ok_o, lp_rd_done_i, hp_rd_req_i, hp_rd_ok_o, hp_rd_done_i, stall;
    logic        trans_wm_en_i, trans_wm_hit_i, buf_full_i;
    logic [3:0]  client_req_i, client_gnt_o, client_hp_i;
    logic [5:0]  tag_level_i;
    logic [7:0]  reg_addr_i, lp_inflight_o, hp_inflight_o;
    logic [31:0] reg_wdata_i, reg_rdata_o, r;
    int unsigned seed = 50015;
    int          n_mismatch = 0, check_count = 0, n, w;
    int          lsb[4] = '{DMA_WB_LIM_LSB, DMA_SB_LIM_LSB, DMA_P5_LIM_LSB, DMA_FC_LIM_LSB};
    dma_arb_ctl i_dma_arb_ctl (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .isoch_primary_i, .isoch_enable_o, .client_req_i, .client_gnt_o, .lp_rd_req_i, .lp_rd_ok_o, .lp_rd_done_i,
        .hp_rd_req_i, .hp_rd_ok_o, .hp_rd_done_i, .tag_level_i, .client_hp_i, .trickle_allow_o, .trans_wm_en_i,
        .trans_wm_hit_i, .buf_full_i, .demote_o, .lp_inflight_o, .hp_inflight_o);
    dma_fabric_model i_lp (.clk_sys_i, .rst_n_i, .issue_i(lp_rd_req_i && lp_rd_ok_o), .stall_i(stall), .done_o(lp_rd_done_i));
    dma_fabric_model i_hp (.clk_sys_i, .rst_n_i, .issue_i(hp_rd_req_i && hp_rd_ok_o), .stall_i(stall), .done_o(hp_rd_done_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Burst length per client and code; only the fifth client tops out at 16
    function automatic logic [31:0] lim(input int c, input int k);
        return (c == DMA_CL_P5 && k == 3) ? 32'h10 : 32'h1 << k;
    endfunction : lim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(reg_rdata_o, exp);
        @(posedge clk_sys_i);
    endtask : rd
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial
    begin
        {rst_n_i, reg_wr_i, reg_rd_i, isoch_primary_i, lp_rd_req_i, hp_rd_req_i, trans_wm_en_i, trans_wm_hit_i} = '0;
        {buf_full_i, client_req_i, client_hp_i, tag_level_i, reg_addr_i, reg_wdata_i, stall} = '0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(DMA_CTL2_OFS, DMA_CTL2_RESET);
        wr(DMA_CTL2_OFS, 32'hffff_ffff);
        rd(DMA_CTL2_OFS, DMA_CTL2_WMASK);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h0);
        r = rnd();
        wr(DMA_CTL2_OFS, r);
        rd(DMA_CTL2_OFS, r & DMA_CTL2_WMASK);
        $display("registers done");
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 4; k++)
            begin
                wr(DMA_CTL2_OFS, DMA_CTL2_RESET & ~(32'h3 << lsb[c]) | 32'(k) << lsb[c]);
                client_req_i <= 4'(1 << c);
                n = 0;
                for (int i = 0; i < 40 && !(n > 0 && client_gnt_o !== 4'(1 << c)); i++)
                begin
                    @(negedge clk_sys_i);
                    if (client_gnt_o === 4'(1 << c)) n++;
                end
                chk(n, lim(c, k));
                @(posedge clk_sys_i);
                client_req_i <= '0;
                repeat (3) @(posedge clk_sys_i);
            end
        $display("bursts done");
        for (int k = 0; k < 4; k++)
        begin
            w = k % 3;
            wr(DMA_CTL2_OFS, DMA_CTL2_RESET & ~32'h633 | 32'(k) << DMA_LP_RD_LSB | 32'(k) << DMA_HP_RD_LSB | 32'(w));
            {stall, lp_rd_req_i, hp_rd_req_i, tag_level_i} <= {3'h7, 6'((8 << w) - 1)};
            repeat (4) @(posedge clk_sys_i);
            chk(hp_inflight_o, 0);
            tag_level_i <= 6'(8 << w);
            repeat (140) @(posedge clk_sys_i);
            chk(lp_inflight_o, k + 1);
            chk(hp_inflight_o, 128 >> k);
            {stall, lp_rd_req_i, hp_rd_req_i} <= '0;
            repeat (140) @(posedge clk_sys_i);
            chk({lp_inflight_o, hp_inflight_o}, 0);
        end
        $display("read limits done");
        for (int i = 0; i < 200; i++)
        begin
            if (i % 50 == 0) wr(DMA_CTL2_OFS, DMA_CTL2_RESET | 32'(i / 50 % 2) << 12 | 32'(i / 100) << 3);
            r = rnd();
            {client_hp_i, trans_wm_en_i, trans_wm_hit_i, buf_full_i, isoch_primary_i} <= r[7:0];
            @(negedge clk_sys_i);
            chk(trickle_allow_o, 32'(i / 50 % 2 == 1 && r[7:4] != 0));
            chk(isoch_enable_o, i / 100);
            if (!(r[3] && !r[2])) chk(demote_o, 32'(i / 100 == 1 && (r[3] ? r[2] : r[1])));
            @(posedge clk_sys_i);
        end
        $display("policy done");
        conclude();
    end
endmodule : dma_arb_ctl_tb
`default_nettype wire
